// file: common/isa_port_cfg.svh
`ifndef ISA_PORT_CFG_SVH
`define ISA_PORT_CFG_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
// System clock rate in hertz.
`define CLK_RATE_HZ 100000000
// Nominal conversion result rate in hertz.
`define CONV_RATE_HZ 200

// ----------------------------------------------------------------------------
// Status register field positions and reset values
// ----------------------------------------------------------------------------
// Input-full flag position.
`define STAT_IN_FULL_BIT 0
// Output-full flag position.
`define STAT_OUT_FULL_BIT 1
// Value of every flag after reset.
`define FLAG_RESET 1'b0
// Idle level of the active-low bus strobes, held in the synchroniser during reset.
`define STROBE_IDLE 1'b1
// Buffer contents after reset.
`define BUF_RESET 8'h00
// Filter mode after reset: pass through.
`define FILTER_RESET 1'b0

// ----------------------------------------------------------------------------
// Host command bytes
// ----------------------------------------------------------------------------
// Read the latest result, three bytes least significant first.
`define CMD_GET_DATA 8'h01
// Read the digital input and output levels.
`define CMD_GET_IO 8'h03
// Pass converter results through unchanged.
`define CMD_FILTER_OFF 8'h10
// Apply the moving average.
`define CMD_FILTER_ON 8'h11
// Upper nibble of the set-outputs command; lower nibble carries the levels.
`define CMD_SET_OUT_HI 4'h2
// Terminating byte after every read transfer.
`define REPLY_OK 8'h00

`endif

// file: common/isa_port_pkg.sv
package isa_port_pkg;

    // Every signal that arrives from outside the clock domain.
    typedef struct packed {
        logic [9:0]  sa;        // I/O address lines.
        logic        ior_n;     // I/O read strobe, active low.
        logic        iow_n;     // I/O write strobe, active low.
        logic [7:0]  data;      // Bus data lines.
        logic [7:0]  jumper;    // Address pattern for bits 9 to 2.
        logic [3:0]  dig_in;    // Digital inputs.
        logic [23:0] adc;       // Converter output word.
    } pin_in_t;

    // Service states of the polling loop, binary coded in loop order CONV, BUS, SEND, IO.
    typedef enum logic [1:0] {
        SVC_CONV = 2'b00,
        SVC_BUS  = 2'b01,
        SVC_IO   = 2'b11,
        SVC_SEND = 2'b10
    } svc_state_t;

endpackage : isa_port_pkg

// file: hdl/pin_sync.sv
// ----------------------------------------------------------------------------
// Two-stage synchroniser for a group of pins
// ----------------------------------------------------------------------------
module pin_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    // First stage; read only by the second stage.
    logic [W-1:0] meta_ff;
    // Second stage, safe for logic to read.
    logic [W-1:0] stable_ff;

    // Both stages reset to the idle pattern chosen by the instance, so that
    // active-low strobes leave reset high and no false strobe edge follows.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            meta_ff <= RST_VAL;
            stable_ff <= RST_VAL;
        end else begin
            meta_ff <= i_async;
            stable_ff <= meta_ff;
        end
    end

    assign o_sync = stable_ff;

endmodule : pin_sync

// file: hdl/isa_host_port_handshake.sv
`include "isa_port_cfg.svh"
module isa_host_port_handshake #(
    parameter int unsigned CONV_CYCLES = `CLK_RATE_HZ / `CONV_RATE_HZ
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic [9:0] i_sa,
    input wire logic i_ior_n,
    input wire logic i_iow_n,
    input wire logic [7:0] i_data,
    input wire logic [7:0] i_addr_jumper,
    input wire logic [3:0] i_dig_in,
    input wire logic [23:0] i_adc_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic [3:0] o_dig_out,
    output logic [23:0] o_result
);

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    isa_port_pkg::pin_in_t raw_in;     // Pins as they arrive.
    isa_port_pkg::pin_in_t pin;        // Pins after two flip-flops.
    // Synchroniser contents during reset: strobes idle high, all else low.
    localparam isa_port_pkg::pin_in_t PIN_IDLE = '{sa: 10'h000, ior_n: `STROBE_IDLE,
        iow_n: `STROBE_IDLE, data: 8'h00, jumper: 8'h00, dig_in: 4'h0, adc: 24'h000000};
    assign raw_in = '{sa: i_sa, ior_n: i_ior_n, iow_n: i_iow_n, data: i_data,
                      jumper: i_addr_jumper, dig_in: i_dig_in, adc: i_adc_data};

    pin_sync #(.W($bits(isa_port_pkg::pin_in_t)), .RST_VAL(PIN_IDLE)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_async(raw_in),
        .o_sync(pin)
    );

    // ------------------------------------------------------------------------
    // Bus decode and strobe edges
    // ------------------------------------------------------------------------
    logic hit;               // Address matches the jumper pattern.
    logic ior_d_ff;          // Read strobe one cycle ago.
    logic iow_d_ff;          // Write strobe one cycle ago.
    logic rd_pend_ff;        // A matched read strobe is in progress.
    logic rd_stat_ff;        // That read addresses the status register.
    logic wr_pend_ff;        // A matched data-port write is in progress.
    logic [7:0] wr_data_ff;  // Byte captured during the write strobe.
    logic wr_done;           // Trailing edge of a data-port write.
    logic rd_done;           // Trailing edge of any matched read.

    assign hit = (pin.sa[9:2] == pin.jumper);
    assign wr_done = wr_pend_ff && !iow_d_ff && pin.iow_n;
    assign rd_done = rd_pend_ff && !ior_d_ff && pin.ior_n;

    // Track strobes; strobes reset high so no false edge follows reset.
    // No bus reset pin exists, so only the power-up reset clears this.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ior_d_ff <= 1'b1;
            iow_d_ff <= 1'b1;
            rd_pend_ff <= 1'b0;
            rd_stat_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_data_ff <= `BUF_RESET;
        end else begin
            ior_d_ff <= pin.ior_n;
            iow_d_ff <= pin.iow_n;
            // Read select is latched while the strobe is low.
            if (!pin.ior_n && hit) begin
                rd_pend_ff <= 1'b1;
                rd_stat_ff <= pin.sa[0];
            end else if (pin.ior_n) begin
                rd_pend_ff <= 1'b0;
            end
            // Data is sampled each cycle the strobe stays low, so the
            // last value before the trailing edge is the one stored.
            // Writes to the status register are ignored.
            if (!pin.iow_n && hit && !pin.sa[0]) begin
                wr_pend_ff <= 1'b1;
                wr_data_ff <= pin.data;
            end else if (pin.iow_n) begin
                wr_pend_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Buffers and handshake flags
    // ------------------------------------------------------------------------
    logic [7:0] in_buf_ff;       // Byte from the host to the processor.
    logic [7:0] out_buf_ff;      // Byte from the processor to the host.
    logic input_full_flag_ff;    // Host byte waiting.
    logic output_full_flag_ff;   // Processor byte waiting.
    logic take_in;               // Processor removes the input byte.
    logic load_out;              // Processor places an output byte.
    logic [7:0] nxt_out_byte;    // Byte placed by the processor.

    // Input side: a host write always lands, even over an unread byte.
    // Set wins over the processor's clear in the same cycle.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            in_buf_ff <= `BUF_RESET;
            input_full_flag_ff <= `FLAG_RESET;
        end else begin
            if (wr_done) begin
                in_buf_ff <= wr_data_ff;
                input_full_flag_ff <= 1'b1;
            end else if (take_in) begin
                input_full_flag_ff <= 1'b0;
            end
        end
    end

    // Output side: cleared only by the trailing edge of a data-port read.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            out_buf_ff <= `BUF_RESET;
            output_full_flag_ff <= `FLAG_RESET;
        end else begin
            if (load_out) begin
                out_buf_ff <= nxt_out_byte;
                output_full_flag_ff <= 1'b1;
            end else if (rd_done && !rd_stat_ff) begin
                output_full_flag_ff <= 1'b0;
            end
        end
    end

    // Drive the bus while a matched read strobe is low.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_data <= `BUF_RESET;
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= hit && !pin.ior_n;
            if (pin.sa[0]) begin
                o_data <= '0;
                o_data[`STAT_IN_FULL_BIT] <= input_full_flag_ff;
                o_data[`STAT_OUT_FULL_BIT] <= output_full_flag_ff;
            end else begin
                o_data <= out_buf_ff;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Conversion pacing and filter
    // ------------------------------------------------------------------------
    logic [31:0] conv_cnt_ff;     // Cycles since the last result.
    logic conv_pend_ff;           // A result is due for service.
    logic avg_mode_ff;            // Moving average selected.
    logic [23:0] hist_ff [0:3];   // Last four converter words.
    logic [25:0] avg_sum;         // Sum over the history window.
    isa_port_pkg::svc_state_t svc_ff; // Current service; the pacing logic reads it.

    // Free-running pacing counter; the pending flag survives until the
    // conversion service runs, so a busy loop delays but never loses it.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            conv_cnt_ff <= '0;
            conv_pend_ff <= 1'b0;
        end else begin
            if (conv_cnt_ff == CONV_CYCLES - 1) begin
                conv_cnt_ff <= '0;
                conv_pend_ff <= 1'b1;
            end else begin
                conv_cnt_ff <= conv_cnt_ff + 32'h00000001;
                if (svc_ff == isa_port_pkg::SVC_CONV) begin
                    conv_pend_ff <= 1'b0;
                end
            end
        end
    end

    assign avg_sum = {2'b00, hist_ff[0]} + {2'b00, hist_ff[1]}
                   + {2'b00, hist_ff[2]} + {2'b00, hist_ff[3]};

    // ------------------------------------------------------------------------
    // Polling service loop
    // ------------------------------------------------------------------------
    logic [7:0] tx_ff [0:3];           // Reply bytes in send order.
    logic [2:0] tx_left_ff;            // Reply bytes still to send.
    logic [1:0] tx_idx_ff;             // Next reply byte.

    assign take_in = (svc_ff == isa_port_pkg::SVC_BUS) && input_full_flag_ff;
    assign load_out = (svc_ff == isa_port_pkg::SVC_SEND) && !output_full_flag_ff
                      && (tx_left_ff != 3'h0);
    assign nxt_out_byte = tx_ff[tx_idx_ff];

    // Each service finishes before the loop moves on; a reply transfer
    // holds the loop until every reply byte has been loaded into the output buffer.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            svc_ff <= isa_port_pkg::SVC_CONV;
            tx_left_ff <= 3'h0;
            tx_idx_ff <= 2'h0;
            avg_mode_ff <= `FILTER_RESET;
            o_dig_out <= 4'h0;
            o_result <= 24'h000000;
            for (int i = 0; i < 4; i++) begin
                hist_ff[i] <= 24'h000000;
                tx_ff[i] <= `REPLY_OK;
            end
        end else begin
            unique case (svc_ff)
                isa_port_pkg::SVC_CONV: begin
                    if (conv_pend_ff) begin
                        hist_ff[0] <= pin.adc;
                        for (int i = 1; i < 4; i++) begin
                            hist_ff[i] <= hist_ff[i-1];
                        end
                        // Average uses the window before this word lands.
                        o_result <= avg_mode_ff ? avg_sum[25:2] : pin.adc;
                    end
                    svc_ff <= isa_port_pkg::SVC_BUS;
                end
                isa_port_pkg::SVC_BUS: begin
                    svc_ff <= isa_port_pkg::SVC_IO;
                    if (input_full_flag_ff) begin
                        tx_idx_ff <= 2'h0;
                        if (in_buf_ff == `CMD_GET_DATA) begin
                            tx_ff[0] <= o_result[7:0];
                            tx_ff[1] <= o_result[15:8];
                            tx_ff[2] <= o_result[23:16];
                            tx_ff[3] <= `REPLY_OK;
                            tx_left_ff <= 3'h4;
                            svc_ff <= isa_port_pkg::SVC_SEND;
                        end else if (in_buf_ff == `CMD_GET_IO) begin
                            tx_ff[0] <= {o_dig_out, pin.dig_in};
                            tx_ff[1] <= `REPLY_OK;
                            tx_left_ff <= 3'h2;
                            svc_ff <= isa_port_pkg::SVC_SEND;
                        end else if (in_buf_ff == `CMD_FILTER_OFF) begin
                            avg_mode_ff <= 1'b0;
                        end else if (in_buf_ff == `CMD_FILTER_ON) begin
                            avg_mode_ff <= 1'b1;
                        end else if (in_buf_ff[7:4] == `CMD_SET_OUT_HI) begin
                            o_dig_out <= in_buf_ff[3:0];
                        end
                    end
                end
                isa_port_pkg::SVC_SEND: begin
                    if (load_out) begin
                        tx_idx_ff <= tx_idx_ff + 2'h1;
                        tx_left_ff <= tx_left_ff - 3'h1;
                    end
                    if (tx_left_ff == 3'h0) begin
                        svc_ff <= isa_port_pkg::SVC_IO;
                    end
                end
                isa_port_pkg::SVC_IO: begin
                    svc_ff <= isa_port_pkg::SVC_CONV;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_write_sets_in: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        wr_done |=> input_full_flag_ff && in_buf_ff == $past(wr_data_ff))
        else $error("Host write did not set input-full.");
    a_take_clears_in: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        take_in && !wr_done |=> !input_full_flag_ff)
        else $error("Processor take did not clear input-full.");
    a_load_sets_out: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        load_out |-> !output_full_flag_ff ##1 output_full_flag_ff)
        else $error("Output load broke the output-full handshake.");
    a_data_read_clr: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        rd_done && !rd_stat_ff && !load_out |=> !output_full_flag_ff)
        else $error("Data read did not clear output-full.");
    a_stat_read_keep: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        rd_done && rd_stat_ff && !load_out |=> $stable(output_full_flag_ff))
        else $error("Status read changed output-full.");
    a_no_drive_miss: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !hit |=> !o_data_oe)
        else $error("Data driven for an unmatched address.");
    a_stat_layout: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        pin.sa[0] |=> o_data[7:2] == 6'h00
            && o_data[`STAT_OUT_FULL_BIT] == $past(output_full_flag_ff))
        else $error("Status byte layout wrong.");
    a_conv_pass: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        svc_ff == isa_port_pkg::SVC_CONV && conv_pend_ff && !avg_mode_ff
            |=> o_result == $past(pin.adc))
        else $error("Pass-through result differs from converter word.");
    a_conv_period: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        conv_cnt_ff == CONV_CYCLES - 1 |=> conv_pend_ff && conv_cnt_ff == 32'h00000000)
        else $error("Conversion pacing off.");

endmodule : isa_host_port_handshake

// file: sim/isa_host_model.sv
// ----------------------------------------------------------------------------
// Host processor on the eight-bit I/O bus
// ----------------------------------------------------------------------------
module isa_host_model (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_dev_data,
    input wire logic i_dev_oe,
    output logic [9:0] o_sa,
    output logic o_ior_n,
    output logic o_iow_n,
    output logic [7:0] o_bus
);
    timeunit 1ns;
    timeprecision 100ps;

    logic host_drv = 1'b0; // High while the host drives the data lines.
    logic [7:0] host_val = 8'h00; // Byte the host places on the lines.
    logic [7:0] last_ff = 8'h00; // Level seen on the lines one cycle ago.

    initial begin
        o_sa = 10'h000;
        o_ior_n = 1'b1;
        o_iow_n = 1'b1;
    end

    // An undriven bus shows the inverse of its last level, so a stale byte never reads back.
    always_comb begin
        o_bus = i_dev_oe ? i_dev_data : (host_drv ? host_val : ~last_ff);
    end

    always_ff @(posedge i_sys_clk) begin
        last_ff <= o_bus;
    end

    // One bus cycle: address first, strobe low for six cycles, then a long recovery.
    // Strobes are far longer than the three-cycle minimum the port needs to see them.
    task automatic cycle(input logic [9:0] addr, input logic rd, input logic [7:0] wdata,
                         output logic [7:0] rdata, output logic saw_oe);
        saw_oe = 1'b0;
        @(posedge i_sys_clk);
        #1;
        o_sa = addr;
        host_drv = !rd;
        host_val = wdata;
        @(posedge i_sys_clk);
        #1;
        o_ior_n = !rd;
        o_iow_n = rd;
        for (int i = 0; i < 6; i++) begin
            @(posedge i_sys_clk);
            #1;
            saw_oe = saw_oe | i_dev_oe;
            rdata = o_bus;
        end
        o_ior_n = 1'b1;
        o_iow_n = 1'b1;
        @(posedge i_sys_clk);
        #1;
        host_drv = 1'b0;
        o_sa = 10'h000;
        repeat (4) @(posedge i_sys_clk);
        #1;
    endtask : cycle
endmodule : isa_host_model

// file: sim/testbench.sv
`include "isa_port_cfg.svh"
// ----------------------------------------------------------------------------
// Self-checking bench for the host port
// ----------------------------------------------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned CONV = 64; // Short conversion period keeps the run brief.
    localparam logic [9:0] BASE = 10'h330; // Jumper pattern 8'hCC selects this base.
    localparam logic [9:0] MISS = 10'h230; // Differs from the base in bit 8.
    localparam logic [23:0] ADC_A = 24'hA5C3E1;
    localparam logic [23:0] ADC_B = 24'h3C5A96;

    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [9:0] sa;
    logic ior_n;
    logic iow_n;
    logic [7:0] bus;
    logic [7:0] o_data;
    logic o_data_oe;
    logic [3:0] dig_in = 4'h9;
    logic [3:0] o_dig_out;
    logic [23:0] adc = ADC_A;
    logic [23:0] o_result;
    logic [7:0] rdat;
    logic oe_seen;
    int mismatches = 0;
    int samples_checked = 0;

    isa_host_port_handshake #(.CONV_CYCLES(CONV)) isa_host_port_handshake_inst (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_sa(sa), .i_ior_n(ior_n),
        .i_iow_n(iow_n), .i_data(bus), .i_addr_jumper(8'hCC), .i_dig_in(dig_in),
        .i_adc_data(adc), .o_data(o_data), .o_data_oe(o_data_oe),
        .o_dig_out(o_dig_out), .o_result(o_result)
    );

    isa_host_model isa_host_model_inst (
        .i_sys_clk(i_sys_clk), .i_dev_data(o_data), .i_dev_oe(o_data_oe),
        .o_sa(sa), .o_ior_n(ior_n), .o_iow_n(iow_n), .o_bus(bus)
    );

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic test_done();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic rd(input logic [9:0] addr);
        isa_host_model_inst.cycle(addr, 1'b1, 8'h00, rdat, oe_seen);
    endtask : rd

    // Polls the status byte; a flag that never arrives ends the run as a failure.
    task automatic wait_stat(input int idx, input logic val);
        for (int i = 0; i < 40; i++) begin
            rd(BASE | 10'h001);
            if (rdat[idx] === val) begin
                return;
            end
        end
        check(rdat, {16'h0000, rdat ^ (8'h01 << idx)});
        test_done();
    endtask : wait_stat

    // The host waits for room before each command byte.
    task automatic send(input logic [7:0] cmd);
        logic [7:0] unused;
        wait_stat(0, 1'b0);
        isa_host_model_inst.cycle(BASE, 1'b0, cmd, unused, oe_seen);
    endtask : send

    // The host reads a reply byte only once one is waiting.
    task automatic reply(input logic [7:0] exp);
        wait_stat(1, 1'b1);
        rd(BASE | 10'h001);
        check(rdat, 8'h02);
        rd(BASE);
        check({oe_seen, rdat}, {1'b1, exp});
    endtask : reply

    task automatic get_data(input logic [23:0] v);
        send(`CMD_GET_DATA);
        for (int b = 0; b < 3; b++) begin
            reply(v[8*b +: 8]);
        end
        reply(`REPLY_OK);
        rd(BASE | 10'h001);
        check(rdat, 8'h00);
    endtask : get_data

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge i_sys_clk);
        #1;
        i_reset = 1'b0;
        rd(BASE | 10'h001);
        check(rdat, 8'h00);
        // A foreign address is neither answered nor obeyed.
        rd(MISS);
        check(oe_seen, 1'b0);
        isa_host_model_inst.cycle(MISS, 1'b0, 8'h2F, rdat, oe_seen);
        // Writes to the status address are dropped.
        isa_host_model_inst.cycle(BASE | 10'h001, 1'b0, 8'h2F, rdat, oe_seen);
        rd(BASE | 10'h001);
        check(rdat, 8'h00);
        check(o_dig_out, 4'h0);
        repeat (2 * CONV) @(posedge i_sys_clk);
        check(o_result, ADC_A);
        get_data(ADC_A);
        // Outputs are set, inputs sampled, and both read back.
        for (int n = 0; n < 2; n++) begin
            dig_in = n ? 4'h6 : 4'h9;
            send({`CMD_SET_OUT_HI, n ? 4'hA : 4'h5});
            wait_stat(0, 1'b0);
            check(o_dig_out, n ? 4'hA : 4'h5);
            send(`CMD_GET_IO);
            reply({n ? 4'hA : 4'h5, dig_in});
            reply(`REPLY_OK);
        end
        // With the averaging filter on, a settled input averages to itself.
        adc = ADC_B;
        send(`CMD_FILTER_ON);
        repeat (7 * CONV) @(posedge i_sys_clk);
        get_data(ADC_B);
        // While averaging, a step input cannot reach the result within two periods.
        adc = ADC_A;
        repeat (2 * CONV) @(posedge i_sys_clk);
        check(o_result === ADC_A, 1'b0);
        send(`CMD_FILTER_OFF);
        repeat (2 * CONV) @(posedge i_sys_clk);
        check(o_result, ADC_A);
        // A reset in mid-reply clears flags, outputs and result.
        send(`CMD_GET_DATA);
        wait_stat(1, 1'b1);
        @(posedge i_sys_clk);
        #1;
        i_reset = 1'b1;
        repeat (12) @(posedge i_sys_clk);
        #1;
        i_reset = 1'b0;
        check({20'h00000, o_dig_out}, 24'h000000);
        check(o_result, 24'h000000);
        rd(BASE | 10'h001);
        check(rdat, 8'h00);
        test_done();
    end

    // Cuts a hung run short.
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        mismatches++;
        test_done();
    end
endmodule : testbench
